// ### pll_clock_gen_registers.sv
// Register bank and base clock selector of the PLL clock generator, Wishbone slave
// Notes on behaviour
// - Lock irq enable: writable and readable only in auto
// - Lock flag sets on each lock change in auto mode
// - Lock flag reads zero outside auto mode
// - Control register read clears lock flag
// - Power-on cannot clear while select is set
// - Reset sets power-on bit
// - Select cannot set while power-on is clear
// - Output held static across source switch
// - Output is half the selected source
// - Prescale bits locked while PLL on
// - Prescale codes give multipliers 1,2,4,8
// - VCO pow2 bits locked while PLL on
// - Lock reads core lock in auto, else zero
// - Acq bit: status in auto, control manual
// - Manual acq value kept during auto mode
// - Multiplier: zero means one, reset 64, locked
// - Linear range: reset 64, locked while on
// - Zero linear range disables PLL, clears select
// - Reference divider: zero means one, reset one
// - Break without clear enable keeps flag
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module pll_clock_gen_registers
  import pll_regs_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Analog core status and source clocks
  input  wire logic             lock_i,
  input  wire logic             acq_status_i,
  input  wire logic             osc_clock_i,
  input  wire logic             divided_vco_clock_i,
  // Debug break
  input  wire logic             break_i,
  input  wire logic             break_clear_enable_i,
  // Core settings
  output logic                  pll_enable_o,
  output logic                  auto_bw_o,
  output logic                  acq_track_o,
  output logic      [1:0]       prescale_bits_o,
  output logic      [1:0]       vco_pow2_bits_o,
  output logic      [MUL_W-1:0] feedback_multiplier_o,
  output logic      [VRS_W-1:0] vco_linear_range_o,
  output logic      [RDS_W-1:0] ref_divide_select_o,
  // Clock output and interrupt request
  output logic                  base_clock_out_o,
  output logic                  lock_irq_o
);
  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Control state
  logic             lock_irq_enable_reg;
  logic             lock_change_flag_reg;
  logic             pll_power_on_reg;
  logic             base_clock_select_reg;
  logic [1:0]       prescale_bits_reg;
  logic [1:0]       vco_pow2_bits_reg;
  logic             auto_bw_reg;
  logic             acq_manual_reg;
  logic [MUL_W-1:0] feedback_multiplier_reg;
  logic [VRS_W-1:0] vco_linear_range_reg;
  logic [RDS_W-1:0] ref_divide_select_reg;
  logic             flag_seen_reg;

  // Synchronisers and filtered inputs
  logic [SYN_N-1:0] sync1_reg;
  logic [SYN_N-1:0] sync2_reg;
  logic [SYN_N-1:0] sync3_reg;
  logic [SYN_N-1:0] filt_reg;
  logic [SYN_N-1:0] filt_prev_reg;

  // Clock selector state
  switch_state_t    sw_state_reg;
  logic             active_select_reg;
  logic [1:0]       osc_edges_reg;
  logic [1:0]       vco_edges_reg;

  // Bus decode
  logic             req;
  logic             fire_wr;
  logic             fire_rd;
  logic             wr_lane;
  logic [7:0]       wbyte;
  logic             lock_view;
  logic             lock_change;
  logic             flag_hold;
  logic             vrs_zero;
  logic [SYN_N-1:0] rise;

  assign req       = cyc_i & stb_i;
  assign fire_wr   = req & ack_o & we_i;
  assign fire_rd   = req & ack_o & ~we_i;
  assign wr_lane   = fire_wr & sel_i[0];
  assign wbyte     = dat_i[7:0];
  assign vrs_zero  = (vco_linear_range_reg == '0);
  assign rise      = filt_reg & ~filt_prev_reg;
  assign flag_hold = break_i & ~break_clear_enable_i;
  assign lock_view   = auto_bw_reg & filt_reg[SYN_LOCK];
  assign lock_change = auto_bw_reg & (filt_reg[SYN_LOCK] ^ filt_prev_reg[SYN_LOCK]);

  function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADR_W'(off));
  endfunction

  // Outside inputs: a change counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < SYN_N; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg[g]     <= 1'b0;
          sync2_reg[g]     <= 1'b0;
          sync3_reg[g]     <= 1'b0;
          filt_reg[g]      <= 1'b0;
          filt_prev_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g]     <= g == SYN_LOCK ? lock_i :
                              g == SYN_ACQ  ? acq_status_i :
                              g == SYN_OSC  ? osc_clock_i : divided_vco_clock_i;
          sync2_reg[g]     <= sync1_reg[g];
          sync3_reg[g]     <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            filt_reg[g] <= sync3_reg[g];
          end
          filt_prev_reg[g] <= filt_reg[g];
        end
      end
    end
  endgenerate

  // Read view of the register bank; unmapped words read zero
  function automatic logic [7:0] read_mux(input logic [ADR_W-1:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (hit(a, OFF_PLL_CONTROL)) begin
      d[CTL_IRQ_EN_BIT] = lock_irq_enable_reg & auto_bw_reg;
      d[CTL_FLAG_BIT]   = lock_change_flag_reg & auto_bw_reg;
      d[CTL_PWR_ON_BIT] = pll_power_on_reg;
      d[CTL_BCS_BIT]    = base_clock_select_reg;
      d[CTL_PRE_LSB+:2] = prescale_bits_reg;
      d[CTL_VPR_LSB+:2] = vco_pow2_bits_reg;
    end else if (hit(a, OFF_PLL_BANDWIDTH)) begin
      d[BW_AUTO_BIT] = auto_bw_reg;
      d[BW_LOCK_BIT] = lock_view;
      d[BW_ACQ_BIT]  = auto_bw_reg ? filt_reg[SYN_ACQ] : acq_manual_reg;
    end else if (hit(a, OFF_MULT_HIGH)) begin
      d[MUL_W-9:0] = feedback_multiplier_reg[MUL_W-1:8];
    end else if (hit(a, OFF_MULT_LOW)) begin
      d = feedback_multiplier_reg[7:0];
    end else if (hit(a, OFF_VCO_RANGE)) begin
      d = vco_linear_range_reg;
    end else if (hit(a, OFF_REF_DIVIDER)) begin
      d[RDS_W-1:0] = ref_divide_select_reg;
    end
    return d;
  endfunction

  // Bus handshake: ack one cycle after the request, data latched with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o         <= 1'b0;
      dat_o         <= 32'h0000_0000;
      flag_seen_reg <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o & ~we_i) begin
        dat_o         <= {24'h00_0000, read_mux(adr_i)};
        flag_seen_reg <= hit(adr_i, OFF_PLL_CONTROL) & lock_change_flag_reg;
      end
    end
  end

  // Lock flag: a read clears only the value sampled at its request, so a late event survives; a control write clears it outright
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_change_flag_reg <= 1'b0;
    end else if (lock_change) begin
      lock_change_flag_reg <= 1'b1;
    end else if (req & ack_o & hit(adr_i, OFF_PLL_CONTROL) & ~flag_hold & ~we_i) begin
      lock_change_flag_reg <= lock_change_flag_reg & ~flag_seen_reg;
    end else if (fire_wr & hit(adr_i, OFF_PLL_CONTROL) & ~flag_hold) begin
      lock_change_flag_reg <= 1'b0;
    end
  end

  // pll_control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_irq_enable_reg   <= 1'b0;
      pll_power_on_reg      <= PWR_RESET;
      base_clock_select_reg <= 1'b0;
      prescale_bits_reg     <= PRE_RESET;
      vco_pow2_bits_reg     <= VPR_RESET;
    end else begin
      if (wr_lane & hit(adr_i, OFF_PLL_CONTROL)) begin
        if (auto_bw_reg) begin
          lock_irq_enable_reg <= wbyte[CTL_IRQ_EN_BIT];
        end
        pll_power_on_reg <= wbyte[CTL_PWR_ON_BIT] | base_clock_select_reg;
        base_clock_select_reg <= wbyte[CTL_BCS_BIT] & pll_power_on_reg & ~vrs_zero;
        if (!pll_power_on_reg) begin
          prescale_bits_reg <= wbyte[CTL_PRE_LSB+:2];
          vco_pow2_bits_reg <= wbyte[CTL_VPR_LSB+:2];
        end
      end else if (vrs_zero) begin
        base_clock_select_reg <= 1'b0;
      end
    end
  end

  // pll_bandwidth_control writes; lock position is status only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_bw_reg    <= 1'b0;
      acq_manual_reg <= 1'b0;
    end else if (wr_lane & hit(adr_i, OFF_PLL_BANDWIDTH)) begin
      auto_bw_reg <= wbyte[BW_AUTO_BIT];
      if (!auto_bw_reg) begin
        acq_manual_reg <= wbyte[BW_ACQ_BIT];
      end
    end
  end

  // Divider settings, all frozen while the PLL is on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feedback_multiplier_reg <= MUL_RESET;
      vco_linear_range_reg    <= VRS_RESET;
      ref_divide_select_reg   <= RDS_RESET;
    end else if (wr_lane & ~pll_power_on_reg) begin
      if (hit(adr_i, OFF_MULT_HIGH)) begin
        feedback_multiplier_reg[MUL_W-1:8] <= wbyte[MUL_W-9:0];
      end else if (hit(adr_i, OFF_MULT_LOW)) begin
        feedback_multiplier_reg[7:0] <= wbyte;
      end else if (hit(adr_i, OFF_VCO_RANGE)) begin
        vco_linear_range_reg <= wbyte;
      end else if (hit(adr_i, OFF_REF_DIVIDER)) begin
        ref_divide_select_reg <= wbyte[RDS_W-1:0];
      end
    end
  end

  // Settings driven to the analog core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_enable_o          <= 1'b0;
      auto_bw_o             <= 1'b0;
      acq_track_o           <= 1'b0;
      prescale_bits_o       <= PRE_RESET;
      vco_pow2_bits_o       <= VPR_RESET;
      feedback_multiplier_o <= MUL_RESET;
      vco_linear_range_o    <= VRS_RESET;
      ref_divide_select_o   <= RDS_RESET;
      lock_irq_o            <= 1'b0;
    end else begin
      pll_enable_o          <= pll_power_on_reg & ~vrs_zero;
      auto_bw_o             <= auto_bw_reg;
      acq_track_o           <= auto_bw_reg ? filt_reg[SYN_ACQ] : acq_manual_reg;
      prescale_bits_o       <= prescale_bits_reg;
      vco_pow2_bits_o       <= vco_pow2_bits_reg;
      feedback_multiplier_o <= (feedback_multiplier_reg == '0) ? MUL_W'(1)
                                                                : feedback_multiplier_reg;
      vco_linear_range_o    <= vco_linear_range_reg;
      ref_divide_select_o   <= (ref_divide_select_reg == '0) ? RDS_W'(1) : ref_divide_select_reg;
      lock_irq_o            <= lock_change_flag_reg & lock_irq_enable_reg & auto_bw_reg;
    end
  end

  // Base clock selector. The sources are sampled, so each must stay well below a
  // quarter of clk_i; a stopped VCO only ends the wait when the PLL is disabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_state_reg      <= SW_RUN;
      active_select_reg <= 1'b0;
      osc_edges_reg     <= 2'h0;
      vco_edges_reg     <= 2'h0;
      base_clock_out_o  <= 1'b0;
    end else begin
      case (sw_state_reg)
        SW_RUN: begin
          // toggle on each rising edge of the selected source
          if (active_select_reg ? rise[SYN_VCO] : rise[SYN_OSC]) begin
            base_clock_out_o <= ~base_clock_out_o;
          end
          if (base_clock_select_reg != active_select_reg) begin
            sw_state_reg  <= SW_WAIT;
            osc_edges_reg <= 2'h0;
            vco_edges_reg <= 2'h0;
          end
        end
        SW_WAIT: begin
          if (rise[SYN_OSC] && osc_edges_reg != SWITCH_EDGES) begin
            osc_edges_reg <= osc_edges_reg + 2'h1;
          end
          if (rise[SYN_VCO] && vco_edges_reg != SWITCH_EDGES) begin
            vco_edges_reg <= vco_edges_reg + 2'h1;
          end
          if (osc_edges_reg == SWITCH_EDGES &&
              (vco_edges_reg == SWITCH_EDGES || !pll_enable_o)) begin
            active_select_reg <= base_clock_select_reg;
            sw_state_reg      <= SW_RUN;
          end
        end
        default: sw_state_reg <= SW_RUN;
      endcase
    end
  end

  property p_ie_hidden;
    (req & ~ack_o & ~we_i & hit(adr_i, OFF_PLL_CONTROL) & ~auto_bw_reg)
      |=> (dat_o[CTL_IRQ_EN_BIT] == 1'b0);
  endproperty
  a_ie_hidden: assert property (p_ie_hidden) else $error("enable visible outside auto");
  // Request follows the enable and mode seen one edge before it
  property p_flag_set;
    lock_change |=> lock_change_flag_reg ##1
      lock_irq_o == $past(lock_irq_enable_reg & auto_bw_reg);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("lock change not flagged");
  property p_flag_hidden;
    (req & ~ack_o & ~we_i & hit(adr_i, OFF_PLL_CONTROL) & ~auto_bw_reg)
      |=> (dat_o[CTL_FLAG_BIT] == 1'b0);
  endproperty
  a_flag_hidden: assert property (p_flag_hidden) else $error("flag visible outside auto");
  property p_read_clear;
    (fire_rd & hit(adr_i, OFF_PLL_CONTROL) & ~flag_hold & ~lock_change & flag_seen_reg)
      |=> !lock_change_flag_reg;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read left flag set");
  property p_on_kept;
    base_clock_select_reg && pll_power_on_reg |=> pll_power_on_reg;
  endproperty
  a_on_kept: assert property (p_on_kept) else $error("power-on cleared while selected");
  property p_sel_guard;
    !pll_power_on_reg && !base_clock_select_reg |=> !base_clock_select_reg;
  endproperty
  a_sel_guard: assert property (p_sel_guard) else $error("select set with PLL off");
  property p_static;
    sw_state_reg == SW_WAIT |=> base_clock_out_o == $past(base_clock_out_o);
  endproperty
  a_static: assert property (p_static) else $error("output moved during switch");
  property p_mul_locked;
    pll_power_on_reg |=> $stable(feedback_multiplier_reg) && $stable(vco_linear_range_reg)
                         && $stable(ref_divide_select_reg) && $stable(prescale_bits_reg);
  endproperty
  a_mul_locked: assert property (p_mul_locked) else $error("setting changed while on");
  property p_zero_range;
    vrs_zero |=> !base_clock_select_reg ##1 !pll_enable_o;
  endproperty
  a_zero_range: assert property (p_zero_range) else $error("zero range left PLL selected");
  property p_hold_break;
    flag_hold && lock_change_flag_reg |=> lock_change_flag_reg;
  endproperty
  a_hold_break: assert property (p_hold_break) else $error("flag cleared in break");

  c_flag_read: cover property (lock_change_flag_reg ##1 fire_rd ##1 !lock_change_flag_reg);
  c_switch_vco: cover property (sw_state_reg == SW_WAIT ##1 active_select_reg);
  c_irq: cover property (lock_irq_o);

endmodule // pll_clock_gen_registers

// ### pll_regs_pkg.sv
// Register map, field layout and reset values of the PLL clock generator register bank
package pll_regs_pkg;

  // Word offsets on the 32-bit bus
  localparam logic [7:0] OFF_PLL_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_PLL_BANDWIDTH = 8'h04;
  localparam logic [7:0] OFF_MULT_HIGH     = 8'h08;
  localparam logic [7:0] OFF_MULT_LOW      = 8'h0C;
  localparam logic [7:0] OFF_VCO_RANGE     = 8'h10;
  localparam logic [7:0] OFF_REF_DIVIDER   = 8'h14;

  // pll_control fields
  localparam int CTL_IRQ_EN_BIT = 7;
  localparam int CTL_FLAG_BIT   = 6;
  localparam int CTL_PWR_ON_BIT = 5;
  localparam int CTL_BCS_BIT    = 4;
  localparam int CTL_PRE_LSB    = 2;
  localparam int CTL_VPR_LSB    = 0;

  // pll_bandwidth_control fields
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;
  localparam int BW_ACQ_BIT  = 5;

  // Field widths
  localparam int MUL_W = 12;
  localparam int VRS_W = 8;
  localparam int RDS_W = 4;

  // Reset values
  localparam logic [MUL_W-1:0] MUL_RESET = 12'h040;
  localparam logic [VRS_W-1:0] VRS_RESET = 8'h40;
  localparam logic [RDS_W-1:0] RDS_RESET = 4'h1;
  localparam logic [1:0]       PRE_RESET = 2'h0;
  localparam logic [1:0]       VPR_RESET = 2'h0;
  localparam logic             PWR_RESET = 1'b1;

  // Source edges to wait for on each clock before a base clock switch completes
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  // Indexes of the synchronised outside inputs
  localparam int SYN_LOCK = 0;
  localparam int SYN_ACQ  = 1;
  localparam int SYN_OSC  = 2;
  localparam int SYN_VCO  = 3;
  localparam int SYN_N    = 4;

  typedef enum logic [0:0] {
    SW_RUN  = 1'b0,
    SW_WAIT = 1'b1
  } switch_state_t;

endpackage

// ### pll_clock_gen_registers_bench.sv
// Self-checking bench for the PLL clock generator register bank
`timescale 1ns/100ps
module pll_clock_gen_registers_bench;
  import pll_regs_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        lock_i = 1'b0;
  logic        acq_status_i = 1'b1;
  logic        osc_clock_i = 1'b0;
  logic        divided_vco_clock_i = 1'b0;
  logic        break_i = 1'b0;
  logic        break_clear_enable_i = 1'b0;
  logic        pll_enable_o;
  logic        auto_bw_o;
  logic        acq_track_o;
  logic [1:0]  prescale_bits_o;
  logic [1:0]  vco_pow2_bits_o;
  logic [11:0] feedback_multiplier_o;
  logic [7:0]  vco_linear_range_o;
  logic [3:0]  ref_divide_select_o;
  logic        base_clock_out_o;
  logic        lock_irq_o;
  int          bad_count = 0;
  int          total_checks = 0;
  int          seed;
  int          osc_cnt = 0;
  int          vco_cnt = 0;

  pll_clock_gen_registers i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .lock_i(lock_i), .acq_status_i(acq_status_i), .osc_clock_i(osc_clock_i),
    .divided_vco_clock_i(divided_vco_clock_i), .break_i(break_i),
    .break_clear_enable_i(break_clear_enable_i), .pll_enable_o(pll_enable_o),
    .auto_bw_o(auto_bw_o), .acq_track_o(acq_track_o), .prescale_bits_o(prescale_bits_o),
    .vco_pow2_bits_o(vco_pow2_bits_o), .feedback_multiplier_o(feedback_multiplier_o),
    .vco_linear_range_o(vco_linear_range_o), .ref_divide_select_o(ref_divide_select_o),
    .base_clock_out_o(base_clock_out_o), .lock_irq_o(lock_irq_o));

  always #4 clk_i = ~clk_i;

  // Slow sources: oscillator period 24 cycles, VCO period 16 cycles
  always @(posedge clk_i) begin
    osc_cnt <= (osc_cnt == 11) ? 0 : osc_cnt + 1;
    vco_cnt <= (vco_cnt == 7) ? 0 : vco_cnt + 1;
    if (osc_cnt == 11) osc_clock_i <= ~osc_clock_i;
    if (vco_cnt == 7) divided_vco_clock_i <= ~divided_vco_clock_i;
  end

  task automatic conclude;
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack and read data are taken at the same rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {$random(seed) & 32'hFFFFFF00} | {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      conclude();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, 4'hF, q);
    chk(q, {24'h0, e});
  endtask

  function automatic logic [11:0] zero_one(input logic [11:0] v);
    return (v == 12'h000) ? 12'h001 : v;
  endfunction

  // Toggle count of the base clock over n cycles, a slip of one accepted unless none expected
  task automatic toggles(input int n, input int e);
    int c;
    logic prev;
    c = 0;
    prev = base_clock_out_o;
    repeat (n) begin
      @(posedge clk_i);
      if (base_clock_out_o !== prev) c++;
      prev = base_clock_out_o;
    end
    if (e > 0 && c >= e - 1 && c <= e + 1) c = e;
    chk(32'(c), 32'(e));
  endtask

  initial begin
    repeat (10000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] q;
    seed = 32'h9552;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_PLL_CONTROL, 8'h20);
    rd(OFF_PLL_BANDWIDTH, 8'h00);
    rd(OFF_MULT_HIGH, 8'h00);
    rd(OFF_MULT_LOW, 8'h40);
    rd(OFF_VCO_RANGE, 8'h40);
    rd(OFF_REF_DIVIDER, 8'h01);
    rd(8'h18, 8'h00);
    chk(32'(pll_enable_o), 32'h1);
    // Settings must not move while the loop runs
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(OFF_MULT_LOW, r[7:0]);
      wr(OFF_VCO_RANGE, r[15:8] | 8'h01);
      wr(OFF_REF_DIVIDER, r[23:16]);
      wr(OFF_PLL_CONTROL, {4'h2, r[27:24]});
    end
    rd(OFF_PLL_CONTROL, 8'h20);
    rd(OFF_MULT_LOW, 8'h40);
    rd(OFF_VCO_RANGE, 8'h40);
    rd(OFF_REF_DIVIDER, 8'h01);
    wr(OFF_PLL_CONTROL, 8'h00);
    rd(OFF_PLL_CONTROL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_PLL_CONTROL, {4'h0, 2'(k), 2'(k % 3)});
      rd(OFF_PLL_CONTROL, {4'h0, 2'(k), 2'(k % 3)});
      chk(32'(prescale_bits_o), 32'(k));
      chk(32'(vco_pow2_bits_o), 32'(k % 3));
    end
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'h0001_0000 : $random(seed);
      wr(OFF_MULT_HIGH, r[7:0]);
      wr(OFF_MULT_LOW, r[15:8]);
      wr(OFF_VCO_RANGE, r[23:16] | 8'h01);
      wr(OFF_REF_DIVIDER, {4'h0, r[27:24]});
      rd(OFF_MULT_HIGH, {4'h0, r[3:0]});
      rd(OFF_VCO_RANGE, r[23:16] | 8'h01);
      chk(32'(vco_linear_range_o), 32'(r[23:16] | 8'h01));
      chk(32'(feedback_multiplier_o), 32'(zero_one({r[3:0], r[15:8]})));
      chk(32'(ref_divide_select_o), 32'(zero_one({8'h0, r[27:24]})));
    end
    wb(1'b1, OFF_MULT_LOW, 8'h55, 4'h0, q);
    rd(OFF_MULT_LOW, r[15:8]);
    wr(OFF_VCO_RANGE, 8'h00);
    wr(OFF_PLL_CONTROL, 8'h20);
    wr(OFF_PLL_CONTROL, 8'h30);
    rd(OFF_PLL_CONTROL, 8'h20);
    chk(32'(pll_enable_o), 32'h0);
    wr(OFF_PLL_CONTROL, 8'h00);
    wr(OFF_VCO_RANGE, 8'h40);
    wr(OFF_PLL_CONTROL, 8'h30);
    rd(OFF_PLL_CONTROL, 8'h20);
    toggles(480, 20);
    wr(OFF_PLL_CONTROL, 8'h30);
    repeat (2) @(posedge clk_i);
    toggles(30, 0);
    repeat (100) @(posedge clk_i);
    toggles(480, 30);
    wr(OFF_PLL_CONTROL, 8'h00);
    rd(OFF_PLL_CONTROL, 8'h20);
    chk(32'(pll_enable_o), 32'h1);
    wr(OFF_PLL_CONTROL, 8'h20);
    // Manual mode hides irq enable, flag and lock
    wr(OFF_PLL_CONTROL, 8'hA0);
    rd(OFF_PLL_CONTROL, 8'h20);
    lock_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rd(OFF_PLL_CONTROL, 8'h20);
    rd(OFF_PLL_BANDWIDTH, 8'h00);
    wr(OFF_PLL_BANDWIDTH, 8'h20);
    rd(OFF_PLL_BANDWIDTH, 8'h20);
    chk(32'(acq_track_o), 32'h1);
    wr(OFF_PLL_BANDWIDTH, 8'hA0);
    acq_status_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(OFF_PLL_BANDWIDTH, 8'h80);
    rd(OFF_PLL_BANDWIDTH, 8'hC0);
    chk(32'(acq_track_o), 32'h0);
    wr(OFF_PLL_CONTROL, 8'hA0);
    rd(OFF_PLL_CONTROL, 8'hA0);
    lock_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(32'(lock_irq_o), 32'h1);
    rd(OFF_PLL_CONTROL, 8'hE0);
    rd(OFF_PLL_CONTROL, 8'hA0);
    repeat (2) @(posedge clk_i);
    chk(32'(lock_irq_o), 32'h0);
    rd(OFF_PLL_BANDWIDTH, 8'h80);
    // Break with and without clear enable
    for (int b = 0; b < 2; b++) begin
      break_i <= 1'b1;
      break_clear_enable_i <= b[0];
      lock_i <= ~lock_i;
      repeat (12) @(posedge clk_i);
      rd(OFF_PLL_CONTROL, 8'hE0);
      wr(OFF_PLL_CONTROL, 8'hA0);
      rd(OFF_PLL_CONTROL, b ? 8'hA0 : 8'hE0);
      break_i <= 1'b0;
      rd(OFF_PLL_CONTROL, b ? 8'hA0 : 8'hE0);
      rd(OFF_PLL_CONTROL, 8'hA0);
    end
    wr(OFF_PLL_BANDWIDTH, 8'h00);
    rd(OFF_PLL_BANDWIDTH, 8'h20);
    rd(OFF_PLL_CONTROL, 8'h20);
    chk(32'(auto_bw_o), 32'h0);
    conclude();
  end
endmodule // pll_clock_gen_registers_bench
